// ### design/dlct_timer.sv
// How it works
// - With count-select set, a timer advances on each falling edge of its event pin.
// - With count-select clear, it counts the system clock if sysclk-select is set, else the prescale tick.
// - A timer counts only while running and ungated or its gate pin is at the chosen level; under split B ignores run and gate, A's high byte ignores gate.
// - Starting a timer keeps the count value it already holds.
// - Mode 0 is a 13-bit counter of high byte and low bits 4..0, flagging overflow on wrap to zero.
// - Timer B mirrors timer A with its own run, gate, flag, gate pin and polarity.
// - Mode 1 uses both bytes as a 16-bit counter.
// - Mode 2 counts the low byte and on wrap sets the flag and reloads it from the high byte.
// - A newly set overflow flag raises the timer interrupt when that interrupt is enabled.
// - In split mode the low byte of A is an 8-bit counter under A's controls and flag.
// - In split mode A's high byte counts clock or prescale only, runs on run_b and sets B's flag.
// - Under split, timer B runs modes 0-2 with no event clock and no flag, but still emits overflow.
// - Under split, timer B runs in modes 0-2 and halts when its own mode is 3.
`timescale 1ns/10ps
`default_nettype none
`include "dlct_consts.svh"
module dlct_timer
  import dlct_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Static configuration
  input wire logic [7:0] i_timer_mode_register,
  input wire logic [7:0] i_clock_select_register,
  input wire logic i_prescale_tick,
  input wire logic i_gate_polarity_a,
  input wire logic i_gate_polarity_b,
  input wire logic i_irq_enable_a,
  input wire logic i_irq_enable_b,
  // Count loading
  input wire logic i_load_a,
  input wire logic i_load_b,
  input wire dlct_count_s i_load_value,
  // Pins
  input wire logic i_event_pin_a,
  input wire logic i_event_pin_b,
  input wire logic i_gate_pin_a,
  input wire logic i_gate_pin_b,
  // Results
  output dlct_count_s o_count_a,
  output dlct_count_s o_count_b,
  output logic o_irq_a,
  output logic o_irq_b,
  output logic o_overflow_b_pulse
);
  dlct_pin_s pin_a;
  dlct_pin_s pin_b;
  logic [7:0] timer_run_control;
  logic [7:0] next_run_control;
  dlct_count_s cnt_a;
  dlct_count_s cnt_b;
  dlct_count_s next_cnt_a;
  dlct_count_s next_cnt_b;
  logic next_ovf_b_pulse;
  logic ovf_b_pulse;
  dlct_mode_e mode_a;
  dlct_mode_e mode_b;
  logic split;
  logic tick_a;
  logic tick_b;
  logic tick_ah;
  logic ovf_a;
  logic ovf_ah;
  logic ovf_b;

  dlct_pin_sync u_sync_a (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_event_pin(i_event_pin_a),
    .i_gate_pin(i_gate_pin_a),
    .o_pin(pin_a)
  );
  dlct_pin_sync u_sync_b (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_event_pin(i_event_pin_b),
    .i_gate_pin(i_gate_pin_b),
    .o_pin(pin_b)
  );

  // Source pulse of one counter
  function automatic logic src_tick(input logic ct, input logic sysclk,
                                    input logic pre, input logic fall);
    if (ct)
      src_tick = fall;
    else if (sysclk)
      src_tick = 1'b1;
    else
      src_tick = pre;
  endfunction

  // Run gate of one counter
  function automatic logic enabled(input logic run, input logic gate,
                                   input logic pin, input logic pol);
    enabled = run & (~gate | (pin == pol));
  endfunction

  // Advance one count in the given mode, returns overflow in bit 16
  function automatic logic [16:0] advance(input dlct_mode_e m, input dlct_count_s c);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [7:0] lo;
    c13 = {c.high, c.low[4:0]};
    c16 = {c.high, c.low};
    lo = c.low;
    case (m)
      DLCT_MODE13:
      begin
        c13 = c13 + 13'h0001;
        advance = {(c13 == 13'h0000), c13[12:5], c.low[7:5], c13[4:0]};
      end
      DLCT_MODE16:
      begin
        c16 = c16 + 16'h0001;
        advance = {(c16 == 16'h0000), c16};
      end
      DLCT_MODE_RELOAD:
      begin
        if (lo == `DLCT_BYTE_MAX)
          advance = {1'b1, c.high, c.high};
        else
          advance = {1'b0, c.high, lo + 8'h01};
      end
      default:
      begin
        lo = lo + 8'h01;
        advance = {(lo == 8'h00), c.high, lo};
      end
    endcase
  endfunction

  assign mode_a = dlct_mode_e'(i_timer_mode_register[1:0]);
  assign mode_b = dlct_mode_e'(i_timer_mode_register[5:4]);
  assign split = (mode_a == DLCT_MODE_SPLIT);

  always_comb
  begin
    logic [16:0] ra;
    logic [16:0] rb;
    logic [7:0] hi;
    ra = 17'h00000;
    rb = 17'h00000;
    hi = 8'h00;
    next_cnt_a = cnt_a;
    next_cnt_b = cnt_b;
    tick_a = enabled(timer_run_control[`DLCT_BIT_RUN_A], i_timer_mode_register[`DLCT_TIMER_MODE_REGISTER_GATE],
                     pin_a.gate_level, i_gate_polarity_a) &
             src_tick(i_timer_mode_register[`DLCT_TIMER_MODE_REGISTER_CT],
                      i_clock_select_register[`DLCT_CK_SYSCLK_A], i_prescale_tick,
                      pin_a.event_fall);
    tick_ah = timer_run_control[`DLCT_BIT_RUN_B] &
              src_tick(1'b0, i_clock_select_register[`DLCT_CK_SYSCLK_A],
                       i_prescale_tick, 1'b0);
    if (split)
      tick_b = (mode_b != DLCT_MODE_SPLIT) &
               src_tick(1'b0, i_clock_select_register[`DLCT_CK_SYSCLK_B],
                        i_prescale_tick, 1'b0);
    else
      tick_b = (mode_b != DLCT_MODE_SPLIT) &
               enabled(timer_run_control[`DLCT_BIT_RUN_B], i_timer_mode_register[7],
                       pin_b.gate_level, i_gate_polarity_b) &
               src_tick(i_timer_mode_register[6], i_clock_select_register[`DLCT_CK_SYSCLK_B],
                        i_prescale_tick, pin_b.event_fall);
    ra = advance(mode_a, cnt_a);
    rb = advance(mode_b, cnt_b);
    ovf_a = tick_a & ra[16];
    ovf_b = tick_b & rb[16];
    hi = cnt_a.high + 8'h01;
    ovf_ah = split & tick_ah & (hi == 8'h00);
    if (tick_a)
      next_cnt_a = ra[15:0];
    if (split)
    begin
      next_cnt_a.high = tick_ah ? hi : cnt_a.high;
      if (tick_a)
        next_cnt_a.low = ra[7:0];
    end
    if (tick_b)
      next_cnt_b = rb[15:0];
    if (i_load_a)
      next_cnt_a = i_load_value;
    if (i_load_b)
      next_cnt_b = i_load_value;
    next_ovf_b_pulse = ovf_b;
    next_run_control = timer_run_control;
    if (i_wr && i_addr == `DLCT_RUN_CTRL_ADDR)
      next_run_control = i_wdata;
    // Hardware set beats software clear
    if (ovf_a)
      next_run_control[`DLCT_BIT_OVF_A] = 1'b1;
    if (ovf_ah || (ovf_b && !split))
      next_run_control[`DLCT_BIT_OVF_B] = 1'b1;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      timer_run_control <= `DLCT_RUN_CTRL_RESET;
      cnt_a <= 16'h0000;
      cnt_b <= 16'h0000;
      ovf_b_pulse <= 1'b0;
    end
    else
    begin
      timer_run_control <= next_run_control;
      cnt_a <= next_cnt_a;
      cnt_b <= next_cnt_b;
      ovf_b_pulse <= next_ovf_b_pulse;
    end
  end

  assign o_rdata = (i_addr == `DLCT_RUN_CTRL_ADDR) ? timer_run_control : 8'h00;
  assign o_count_a = cnt_a;
  assign o_count_b = cnt_b;
  assign o_irq_a = timer_run_control[`DLCT_BIT_OVF_A] & i_irq_enable_a;
  assign o_irq_b = timer_run_control[`DLCT_BIT_OVF_B] & i_irq_enable_b;
  assign o_overflow_b_pulse = ovf_b_pulse;
endmodule // dlct_timer
`default_nettype wire

// ### design/dlct_consts.svh
`ifndef DLCT_CONSTS_SVH
`define DLCT_CONSTS_SVH
`define DLCT_RUN_CTRL_ADDR 8'h88
`define DLCT_RUN_CTRL_RESET 8'h00
`define DLCT_BIT_OVF_B 7
`define DLCT_BIT_RUN_B 6
`define DLCT_BIT_OVF_A 5
`define DLCT_BIT_RUN_A 4
`define DLCT_MODE_RESET 8'h00
`define DLCT_CLKSEL_RESET 8'h00
`define DLCT_TIMER_MODE_REGISTER_MODE_LO 0
`define DLCT_TIMER_MODE_REGISTER_CT 2
`define DLCT_TIMER_MODE_REGISTER_GATE 3
`define DLCT_TIMER_MODE_REGISTER_B_SHIFT 4
`define DLCT_CK_SYSCLK_A 3
`define DLCT_CK_SYSCLK_B 4
`define DLCT_CNT13_MAX 13'h1FFF
`define DLCT_BYTE_MAX 8'hFF
`endif

// ### design/dlct_pkg.sv
package dlct_pkg;
  typedef enum logic [1:0] {
    DLCT_MODE13,
    DLCT_MODE16,
    DLCT_MODE_RELOAD,
    DLCT_MODE_SPLIT
  } dlct_mode_e;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dlct_count_s;
  typedef struct packed {
    logic event_fall;
    logic gate_level;
  } dlct_pin_s;
endpackage

// ### design/dlct_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dlct_pin_sync
  import dlct_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Raw pins
  input wire logic i_event_pin,
  input wire logic i_gate_pin,
  // Conditioned pins
  output dlct_pin_s o_pin
);
  logic [2:0] ev_sr;
  logic [1:0] gt_sr;
  logic [2:0] next_ev_sr;
  logic [1:0] next_gt_sr;
  always_comb
  begin
    next_ev_sr = {ev_sr[1:0], i_event_pin};
    next_gt_sr = {gt_sr[0], i_gate_pin};
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ev_sr <= 3'h7;
      gt_sr <= 2'h0;
    end
    else
    begin
      ev_sr <= next_ev_sr;
      gt_sr <= next_gt_sr;
    end
  end
  // Falling edge from the two settled samples
  assign o_pin.event_fall = ev_sr[2] & ~ev_sr[1];
  assign o_pin.gate_level = gt_sr[1];
endmodule // dlct_pin_sync
`default_nettype wire

// ### verif/dlct_timer_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module dlct_timer_asserts
  import dlct_pkg::*;
(
  // Watched ports
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_timer_mode_register,
  input wire logic [7:0] i_clock_select_register,
  input wire logic i_irq_enable_a,
  input wire logic i_load_a,
  input wire dlct_count_s o_count_a,
  input wire logic o_irq_a,
  input wire logic o_overflow_b_pulse
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  wire logic sel = i_addr == 8'h88;
  wire logic [1:0] ma = i_timer_mode_register[1:0];
  wire logic [12:0] c13a = {o_count_a.high, o_count_a.low[4:0]};
  wire logic on_a = sel && o_rdata[4] && !i_load_a && i_timer_mode_register[3:2] == 2'h0
    && i_clock_select_register[3];
  a_irq_a_follow: assert property (sel |-> o_irq_a == (o_rdata[5] && i_irq_enable_a))
    else $error("irq a mismatch");
  a_stop_hold: assert property (sel && !o_rdata[4] && ma != 2'h3 && !i_load_a
    |=> $stable(o_count_a)) else $error("stopped timer moved");
  a_step_16: assert property (on_a && ma == 2'h1
    |=> o_count_a == $past(o_count_a) + 16'h1) else $error("16-bit step wrong");
  a_wrap_13: assert property (on_a && ma == 2'h0 && c13a == 13'h1FFF ##1 sel
    |-> o_rdata[5] && c13a == 13'h0000) else $error("13-bit wrap wrong");
  a_keep_upper: assert property (ma == 2'h0 && !i_load_a
    |=> $stable(o_count_a.low[7:5])) else $error("low upper bits changed");
  a_reload_wrap: assert property (on_a && ma == 2'h2 && o_count_a.low == 8'hFF
    |=> o_count_a.low == $past(o_count_a.high) && $stable(o_count_a.high))
    else $error("reload wrong");
  a_flag_b_pulse: assert property (o_overflow_b_pulse && sel && $past(ma) != 2'h3
    |-> o_rdata[7]) else $error("flag b not set");
  a_run_write: assert property (i_wr && sel ##1 sel
    |-> o_rdata[6] == $past(i_wdata[6]) && o_rdata[4] == $past(i_wdata[4]))
    else $error("run bits not written");
  c_reload: cover property (on_a && ma == 2'h2 && o_count_a.low == 8'hFF);
  c_pulse_b: cover property (o_overflow_b_pulse);
  c_irq_a: cover property (o_irq_a);
endmodule // dlct_timer_asserts
bind dlct_timer dlct_timer_asserts u_chk (.i_mclk, .i_rst, .i_addr, .i_wr, .i_wdata, .o_rdata,
  .i_timer_mode_register, .i_clock_select_register, .i_irq_enable_a, .i_load_a, .o_count_a,
  .o_irq_a, .o_overflow_b_pulse);
`default_nettype wire

// ### verif/dlct_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module dlct_pin_model (
  // Control
  input wire logic i_mclk,
  input wire logic i_fire,
  input wire logic i_sel_b,
  input wire logic [3:0] i_hold,
  input wire logic i_gate_a,
  input wire logic i_gate_b,
  // Pins
  output logic o_event_pin_a,
  output logic o_event_pin_b,
  output logic o_gate_pin_a,
  output logic o_gate_pin_b
);
  logic lo = 1'b0;
  int cnt = 0;
  // Low phase held i_hold+1 clocks, then high phase held i_hold clocks
  always @(posedge i_mclk)
  begin
    if (i_fire && cnt == 0)
    begin
      lo <= 1'b1;
      cnt <= 2 * i_hold;
    end
    else if (cnt != 0)
    begin
      cnt <= cnt - 1;
      if (cnt == i_hold)
        lo <= 1'b0;
    end
  end
  assign o_event_pin_a = !(lo && !i_sel_b);
  assign o_event_pin_b = !(lo && i_sel_b);
  assign o_gate_pin_a = i_gate_a;
  assign o_gate_pin_b = i_gate_b;
endmodule // dlct_pin_model
`default_nettype wire

// ### verif/dlct_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dlct_timer_tb;
  import dlct_pkg::*;
  logic i_mclk = 0, i_rst = 1, i_wr = 0, i_load_a = 0, i_load_b = 0, pt = 0, fire = 0, ga = 0;
  logic pa = 1, sb = 0;
  logic [3:0] hold = 4'h2;
  logic [7:0] i_addr = 8'h88, i_wdata = 8'h00, tm = 8'h00, ck = 8'h18, o_rdata;
  dlct_count_s i_load_value = 16'h0000, o_count_a, o_count_b;
  logic o_irq_a, o_irq_b, pb;
  wire logic ea, eb, gpa, gpb;
  int err_count = 0, samples_checked = 0, cyc = 0, seed = 32'hf831, v;
  dlct_timer dut (.i_mclk, .i_rst, .i_addr, .i_wr, .i_wdata, .o_rdata, .i_timer_mode_register(tm),
    .i_clock_select_register(ck), .i_prescale_tick(pt), .i_gate_polarity_a(pa),
    .i_gate_polarity_b(1'b1), .i_irq_enable_a(1'b1), .i_irq_enable_b(1'b1), .i_load_a,
    .i_load_b, .i_load_value, .i_event_pin_a(ea), .i_event_pin_b(eb), .i_gate_pin_a(gpa),
    .i_gate_pin_b(gpb), .o_count_a, .o_count_b, .o_irq_a, .o_irq_b, .o_overflow_b_pulse(pb));
  dlct_pin_model pins (.i_mclk, .i_fire(fire), .i_sel_b(sb), .i_hold(hold), .i_gate_a(ga),
    .i_gate_b(1'b0), .o_event_pin_a(ea), .o_event_pin_b(eb), .o_gate_pin_a(gpa),
    .o_gate_pin_b(gpb));
  initial
    forever #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      err_count++;
      end_sim;
    end
  end
  always @(negedge i_mclk)
    pt <= cyc[1:0] == 2'h0;
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(string n, logic [15:0] e, logic [15:0] s);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(logic [7:0] d);
    @(negedge i_mclk);
    i_wr = 1;
    i_wdata = d;
    @(negedge i_mclk);
    i_wr = 0;
  endtask
  task ld(bit b, logic [15:0] d);
    @(negedge i_mclk);
    i_load_a = !b;
    i_load_b = b;
    i_load_value = d;
    @(negedge i_mclk);
    i_load_a = 0;
    i_load_b = 0;
  endtask
  // Run bit stands for exactly n sampling edges
  task run(logic [7:0] r, int n);
    @(negedge i_mclk);
    i_wr = 1;
    i_wdata = r;
    @(negedge i_mclk);
    if (n > 1)
    begin
      i_wr = 0;
      repeat (n - 1) @(negedge i_mclk);
      i_wr = 1;
    end
    i_wdata = 8'h00;
    @(negedge i_mclk);
    i_wr = 0;
  endtask
  task pulse(logic [3:0] h);
    @(negedge i_mclk);
    hold = h;
    fire = 1;
    @(negedge i_mclk);
    fire = 0;
    repeat (2 * h + 2) @(negedge i_mclk);
  endtask
  initial
  begin
    repeat (5) @(negedge i_mclk);
    i_rst = 0;
    chk("run_ctrl", 16'h0000, o_rdata);
    i_addr = 8'h89;
    wr(8'hFF);
    chk("unmapped", 16'h0000, o_rdata);
    i_addr = 8'h88;
    @(negedge i_mclk);
    chk("run_ctrl", 16'h0000, o_rdata);
    tm = 8'h11;
    for (int b = 0; b < 2; b++)
    begin
      v = $random(seed);
      ld(b, v[15:0]);
      run(b ? 8'h40 : 8'h10, 5 + b);
      chk("count16", 16'(v + 5 + b), b ? o_count_b : o_count_a);
    end
    ck = 8'h00;
    ld(0, v[15:0]);
    run(8'h10, 16);
    chk("prescaled", 16'(v + 4), o_count_a);
    $display("test clock sources done");
    ck = 8'h18;
    tm = 8'h10;
    ld(0, 16'hFFFF);
    run(8'h10, 1);
    chk("count13", 16'h00E0, o_count_a);
    chk("irq_a", 16'h0003, {o_irq_a, o_rdata[5]});
    tm = 8'h12;
    v = $random(seed);
    ld(0, {v[7:0], 8'hFE});
    run(8'h10, 2);
    chk("reload", {v[7:0], v[7:0]}, o_count_a);
    $display("test modes done");
    tm = 8'h19;
    ld(0, 16'h0000);
    run(8'h10, 8);
    chk("gated", 16'h0000, o_count_a);
    ga = 1;
    repeat (4) @(negedge i_mclk);
    run(8'h10, 6);
    chk("gated", 16'h0006, o_count_a);
    pa = 0;
    ga = 0;
    repeat (4) @(negedge i_mclk);
    run(8'h10, 3);
    chk("gated_low", 16'h0009, o_count_a);
    tm = 8'h15;
    ld(0, 16'h0000);
    wr(8'h10);
    for (int i = 0; i < 4; i++)
      pulse(i[0] ? 4'h5 : 4'h2);
    wr(8'h00);
    chk("events", 16'h0004, o_count_a);
    tm = 8'h55;
    sb = 1;
    ld(1, 16'h0000);
    wr(8'h40);
    for (int i = 0; i < 2; i++)
      pulse(4'h2);
    wr(8'h00);
    chk("events_b", 16'h0002, o_count_b);
    $display("test gate and events done");
    tm = 8'h13;
    ld(0, 16'hFF00);
    run(8'h40, 1);
    chk("split", 16'h0000, o_count_a);
    chk("flag_b", 16'h0001, o_rdata[7]);
    tm = 8'h33;
    ld(1, 16'h0000);
    repeat (4) @(negedge i_mclk);
    chk("halt_b", 16'h0000, o_count_b);
    wr(8'h00);
    tm = 8'h10;
    ld(1, 16'hFFFF);
    run(8'h40, 1);
    chk("irq_b", 16'h0003, {o_irq_b, o_rdata[7]});
    $display("test split and timer b done");
    end_sim;
  end
endmodule // dlct_timer_tb
`default_nettype wire
